// ==== design/pp_params.svh ====
// constants for the parallel program/erase port
`ifndef PP_PARAMS_SVH
`define PP_PARAMS_SVH
`define PP_MODE_ADDR        2'b00
`define PP_MODE_DATA        2'b01
`define PP_MODE_CMD         2'b10
`define PP_MODE_IDLE        2'b11
`define PP_CMD_CHIP_ERASE   8'h80
`define PP_CMD_WRITE_FLASH  8'h10
`define PP_CMD_NONE         8'h00
`define PP_ADDR_RESET       8'h00
`define PP_FLASH_WORDS      1024
`define PP_EEPROM_BYTES     128
`define PP_ERASE_CYCLES     8
`define PP_FIFO_DEPTH       8
`endif

// ==== design/pp_pkg.sv ====
// types for the parallel program/erase port
package pp_pkg;
    typedef enum logic [2:0] {
        ST_IDLE      = 3'b000,
        ST_ERASE_FL  = 3'b001,
        ST_ERASE_EE  = 3'b011,
        ST_UNLOCK    = 3'b010,
        ST_PROGRAM   = 3'b110
    } pp_state_t;
endpackage

// ==== design/pp_fifo.sv ====
// small synchronous fifo for the page data path
`timescale 1ns/10ps
`default_nettype none
module pp_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    input  wire logic             i_ref_clk,
    input  wire logic             i_resetn,
    input  wire logic [WIDTH-1:0] i_wr_data,
    input  wire logic             i_wr_valid,
    output logic                  o_wr_ready,
    output logic      [WIDTH-1:0] o_rd_data,
    output logic                  o_rd_valid,
    input  wire logic             i_rd_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wp_r;
    logic [AW-1:0]    rp_r;
    logic [AW:0]      cnt_r;
    logic             push;
    logic             pop;

    assign o_wr_ready = (cnt_r != (AW+1)'(DEPTH));
    assign o_rd_valid = (cnt_r != '0);
    assign push       = i_wr_valid && o_wr_ready;
    assign pop        = o_rd_valid && i_rd_ready;
    assign o_rd_data  = mem[rp_r];

    always_ff @(posedge i_ref_clk) begin
        if (push) begin
            mem[wp_r] <= i_wr_data;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_resetn) begin
            wp_r  <= '0;
            rp_r  <= '0;
            cnt_r <= '0;
        end else begin
            if (push) begin
                wp_r <= (wp_r == AW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
            end
            if (pop) begin
                rp_r <= (rp_r == AW'(DEPTH-1)) ? '0 : rp_r + 1'b1;
            end
            cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule // pp_fifo
`default_nettype wire

// ==== design/pp_port.sv ====
// parallel programming port: command/address latch, chip erase, flash page write
`include "pp_params.svh"
// ---------------------------------------------------------------------------
// Functional notes
// - command and high address held for whole session; low address steps up per buffered word, stopping at 0xff
// - high address byte stays latched between windows
// - chip erase clears flash, eeprom, lock bits
// - lock bits released after flash fully erased
// - chip erase never alters fuse bits
// - mode 10 with byte select low loads command
// - data latched on load strobe rising edge
// - 0x80 decodes as chip erase
// - write strobe low pulse starts erase, busy low
// - eeprom preserve fuse keeps eeprom on erase
// - 0x10 decodes as write flash
// - mode 00 loads an address byte
// - byte select low targets low address byte
// - flash data buffered per page, then programmed
// ---------------------------------------------------------------------------
`timescale 1ns/10ps
`default_nettype none
module pp_port #(
    parameter int FLASH_WORDS  = `PP_FLASH_WORDS,
    parameter int EEPROM_BYTES = `PP_EEPROM_BYTES,
    parameter int PAGE_WORDS   = `PP_FIFO_DEPTH,
    parameter int ERASE_CYCLES = `PP_ERASE_CYCLES
) (
    input  wire logic        i_ref_clk,
    input  wire logic        i_resetn,
    input  wire logic        i_action_select_high,
    input  wire logic        i_action_select_low,
    input  wire logic        i_byte_select,
    input  wire logic        i_load_strobe,
    input  wire logic        i_write_strobe_n,
    input  wire logic [7:0]  i_data,
    input  wire logic        i_eeprom_preserve_fuse,
    input  wire logic [7:0]  i_fuse_bits,
    output logic             o_ready_busy_n,
    output logic      [7:0]  o_command,
    output logic      [7:0]  o_addr_low,
    output logic      [7:0]  o_addr_high,
    output logic             o_lock_bits_set,
    output logic             o_flash_erased,
    output logic             o_eeprom_erased,
    output logic      [7:0]  o_fuse_bits,
    output logic             o_page_written,
    output logic      [15:0] o_page_word
);
    // -----------------------------------------------------------------------
    // pin synchronisers
    // -----------------------------------------------------------------------
    // every pin but i_fuse_bits is asynchronous to i_ref_clk, so all of them pass two flops
    logic [12:0] sync1_r;
    logic [12:0] sync2_r;
    logic        load_d_r;
    logic        wr_d_r;
    always_ff @(posedge i_ref_clk) begin
        if (!i_resetn) begin
            sync1_r <= 13'h0c00;
            sync2_r <= 13'h0c00;
        end else begin
            sync1_r <= {i_load_strobe, i_write_strobe_n, i_eeprom_preserve_fuse,
                        i_action_select_high, i_action_select_low, i_byte_select,
                        i_data[6:0]} & 13'h1fff;
            sync2_r <= sync1_r;
        end
    end
    // msb of data carried in its own pair to keep the vector readable
    logic data7_1_r;
    logic data7_2_r;
    always_ff @(posedge i_ref_clk) begin
        if (!i_resetn) begin
            data7_1_r <= 1'b0;
            data7_2_r <= 1'b0;
        end else begin
            data7_1_r <= i_data[7];
            data7_2_r <= data7_1_r;
        end
    end

    logic       load_s;
    logic       wr_n_s;
    logic       keep_ee_s;
    logic [1:0] mode_s;
    logic       bsel_s;
    logic [7:0] data_s;
    assign load_s    = sync2_r[12];
    assign wr_n_s    = sync2_r[11];
    assign keep_ee_s = sync2_r[10];
    assign mode_s    = sync2_r[9:8];
    assign bsel_s    = sync2_r[7];
    assign data_s    = {data7_2_r, sync2_r[6:0]};

    always_ff @(posedge i_ref_clk) begin
        if (!i_resetn) begin
            load_d_r <= 1'b0;
            wr_d_r   <= 1'b1;
        end else begin
            load_d_r <= load_s;
            wr_d_r   <= wr_n_s;
        end
    end

    logic load_rise;
    logic wr_fall;
    assign load_rise = load_s && !load_d_r;
    assign wr_fall   = !wr_n_s && wr_d_r;

    // -----------------------------------------------------------------------
    // state
    // -----------------------------------------------------------------------
    pp_pkg::pp_state_t state_r;
    pp_pkg::pp_state_t state_nxt;
    logic [15:0]       cnt_r;
    logic              busy;
    assign busy = (state_r != pp_pkg::ST_IDLE);

    // -----------------------------------------------------------------------
    // command and address latches
    // -----------------------------------------------------------------------
    // strobes are ignored while busy; the programmer must wait anyway
    logic [7:0] cmd_r;
    logic [7:0] addr_lo_r;
    logic [7:0] addr_hi_r;
    logic [7:0] data_lo_r;
    logic       word_push;
    always_ff @(posedge i_ref_clk) begin
        if (!i_resetn) begin
            cmd_r <= `PP_CMD_NONE;
        end else if (load_rise && !busy && mode_s == `PP_MODE_CMD && !bsel_s) begin
            cmd_r <= data_s;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_resetn) begin
            addr_lo_r <= `PP_ADDR_RESET;
            addr_hi_r <= `PP_ADDR_RESET;
        end else if (load_rise && !busy && mode_s == `PP_MODE_ADDR) begin
            if (!bsel_s) begin
                addr_lo_r <= data_s;
            end else begin
                addr_hi_r <= data_s;
            end
        end else if (word_push && addr_lo_r != 8'hff) begin
            addr_lo_r <= addr_lo_r + 8'h01;
        end
    end

    // -----------------------------------------------------------------------
    // page data path
    // -----------------------------------------------------------------------
    logic        fifo_ready;
    logic        fifo_valid;
    logic [15:0] fifo_data;
    logic        byte_hi_r;
    logic        is_write;
    assign is_write  = (cmd_r == `PP_CMD_WRITE_FLASH);
    // a high byte right after another high byte is dropped rather than paired with stale data
    assign word_push = load_rise && !busy && is_write && mode_s == `PP_MODE_DATA
                       && bsel_s && !byte_hi_r && fifo_ready;

    always_ff @(posedge i_ref_clk) begin
        if (!i_resetn) begin
            data_lo_r <= 8'h00;
            byte_hi_r <= 1'b0;
        end else if (load_rise && !busy && is_write && mode_s == `PP_MODE_DATA) begin
            if (!bsel_s) begin
                data_lo_r <= data_s;
            end
            byte_hi_r <= bsel_s;
        end
    end

    // a full fifo drops the strobe; depth equals one page so this marks page end
    pp_fifo #(
        .WIDTH (16),
        .DEPTH (PAGE_WORDS)
    ) u_page (
        .i_ref_clk  (i_ref_clk),
        .i_resetn   (i_resetn),
        .i_wr_data  ({data_s, data_lo_r}),
        .i_wr_valid (word_push),
        .o_wr_ready (fifo_ready),
        .o_rd_data  (fifo_data),
        .o_rd_valid (fifo_valid),
        .i_rd_ready (state_r == pp_pkg::ST_PROGRAM)
    );

    // -----------------------------------------------------------------------
    // sequencer
    // -----------------------------------------------------------------------
    logic erase_go;
    logic prog_go;
    assign erase_go = wr_fall && cmd_r == `PP_CMD_CHIP_ERASE;
    assign prog_go  = wr_fall && is_write && fifo_valid;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            pp_pkg::ST_IDLE: begin
                if (erase_go) begin
                    state_nxt = pp_pkg::ST_ERASE_FL;
                end else if (prog_go) begin
                    state_nxt = pp_pkg::ST_PROGRAM;
                end
            end
            pp_pkg::ST_ERASE_FL: begin
                if (cnt_r == 16'(ERASE_CYCLES - 1)) begin
                    state_nxt = keep_ee_s ? pp_pkg::ST_UNLOCK
                                          : pp_pkg::ST_ERASE_EE;
                end
            end
            pp_pkg::ST_ERASE_EE: begin
                if (cnt_r == 16'(ERASE_CYCLES - 1)) begin
                    state_nxt = pp_pkg::ST_UNLOCK;
                end
            end
            pp_pkg::ST_UNLOCK: begin
                state_nxt = pp_pkg::ST_IDLE;
            end
            pp_pkg::ST_PROGRAM: begin
                if (!fifo_valid) begin
                    state_nxt = pp_pkg::ST_IDLE;
                end
            end
            default: begin
                state_nxt = pp_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_resetn) begin
            state_r <= pp_pkg::ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_resetn || state_nxt != state_r) begin
            cnt_r <= 16'h0000;
        end else begin
            cnt_r <= cnt_r + 16'h0001;
        end
    end

    // -----------------------------------------------------------------------
    // memory condition flags
    // -----------------------------------------------------------------------
    // lock bits set by reset as a stand-in for a locked part
    logic lock_r;
    logic fl_erased_r;
    logic ee_erased_r;
    logic page_wr_r;
    logic [15:0] word_r;
    always_ff @(posedge i_ref_clk) begin
        if (!i_resetn) begin
            lock_r <= 1'b1;
        end else if (state_r == pp_pkg::ST_UNLOCK) begin
            lock_r <= 1'b0;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_resetn) begin
            fl_erased_r <= 1'b0;
            ee_erased_r <= 1'b0;
        end else begin
            if (state_r == pp_pkg::ST_ERASE_FL && state_nxt != state_r) begin
                fl_erased_r <= 1'b1;
            end else if (state_r == pp_pkg::ST_PROGRAM) begin
                fl_erased_r <= 1'b0;
            end
            if (state_r == pp_pkg::ST_ERASE_EE && state_nxt != state_r) begin
                ee_erased_r <= 1'b1;
            end
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_resetn) begin
            page_wr_r <= 1'b0;
            word_r    <= 16'h0000;
        end else begin
            page_wr_r <= (state_r == pp_pkg::ST_PROGRAM) && fifo_valid;
            if (state_r == pp_pkg::ST_PROGRAM && fifo_valid) begin
                word_r <= fifo_data;
            end
        end
    end

    // -----------------------------------------------------------------------
    // outputs
    // -----------------------------------------------------------------------
    assign o_ready_busy_n  = !busy;
    assign o_command       = cmd_r;
    assign o_addr_low      = addr_lo_r;
    assign o_addr_high     = addr_hi_r;
    assign o_lock_bits_set = lock_r;
    assign o_flash_erased  = fl_erased_r;
    assign o_eeprom_erased = ee_erased_r;
    assign o_fuse_bits     = i_fuse_bits;
    assign o_page_written  = page_wr_r;
    assign o_page_word     = word_r;
endmodule // pp_port
`default_nettype wire

// ==== sim/pp_port_checker.sv ====
// concurrent checks on the pins of the parallel program/erase port
`timescale 1ns/10ps
`default_nettype none
module pp_port_checker #(
    parameter int ERASE_CYCLES = 8
) (
    input wire logic        i_ref_clk,
    input wire logic        i_resetn,
    input wire logic        i_eeprom_preserve_fuse,
    input wire logic [7:0]  i_fuse_bits,
    input wire logic        o_ready_busy_n,
    input wire logic [7:0]  o_command,
    input wire logic [7:0]  o_addr_high,
    input wire logic        o_lock_bits_set,
    input wire logic        o_flash_erased,
    input wire logic        o_eeprom_erased,
    input wire logic [7:0]  o_fuse_bits,
    input wire logic        o_page_written
);
    // ------------------------------------------------------------
    // erase timing, reset values, fuse, flag, latch hold and page write checks
    // ------------------------------------------------------------
    localparam int BUSY_MAX = 2 * ERASE_CYCLES + 4;
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_resetn);
    sequence s_erase_start;
        $fell(o_ready_busy_n) && o_command == 8'h80;
    endsequence
    sequence s_busy_run;
        !o_ready_busy_n [*8];
    endsequence
    a_reset_values: assert property (disable iff (1'b0) !i_resetn |=>
        o_ready_busy_n && o_lock_bits_set && o_command == 8'h00 && !o_flash_erased)
        else $error("wrong state after reset");
    a_fuse_passthru: assert property (o_fuse_bits == i_fuse_bits)
        else $error("fuse bits altered");
    a_erase_busy_min: assert property (s_erase_start |-> s_busy_run)
        else $error("erase busy too short");
    a_erase_busy_max: assert property (s_erase_start |-> ##[9:BUSY_MAX] o_ready_busy_n)
        else $error("erase busy too long");
    a_lock_after_flash: assert property ($fell(o_lock_bits_set) |-> o_flash_erased)
        else $error("lock released before flash erased");
    a_erase_cmd: assert property ($rose(o_flash_erased) |-> !o_ready_busy_n && o_command == 8'h80)
        else $error("flash erased outside an erase");
    a_ee_preserve: assert property ($rose(o_eeprom_erased) |-> !i_eeprom_preserve_fuse)
        else $error("eeprom erased though preserved");
    a_latch_hold: assert property (!o_ready_busy_n |=> $stable(o_command))
        else $error("command changed while busy");
    a_unlock_ready: assert property ($fell(o_lock_bits_set) |-> ##[0:1] o_ready_busy_n)
        else $error("not ready after unlock");
    a_page_cmd: assert property (o_page_written |-> o_command == 8'h10)
        else $error("page written without write command");
    a_addr_hold: assert property (!o_ready_busy_n |=> $stable(o_addr_high))
        else $error("high address changed while busy");
endmodule // pp_port_checker
bind pp_port pp_port_checker #(.ERASE_CYCLES(ERASE_CYCLES)) u_chk (
    .i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_eeprom_preserve_fuse(i_eeprom_preserve_fuse),
    .i_fuse_bits(i_fuse_bits), .o_ready_busy_n(o_ready_busy_n), .o_command(o_command),
    .o_addr_high(o_addr_high), .o_lock_bits_set(o_lock_bits_set),
    .o_flash_erased(o_flash_erased), .o_eeprom_erased(o_eeprom_erased),
    .o_fuse_bits(o_fuse_bits), .o_page_written(o_page_written));
`default_nettype wire

// ==== sim/pp_programmer_model.sv ====
// model of the external parallel programmer driving the port pins
`timescale 1ns/10ps
`default_nettype none
module pp_programmer_model (
    input  wire logic       i_ref_clk,
    output logic            o_action_select_high,
    output logic            o_action_select_low,
    output logic            o_byte_select,
    output logic            o_load_strobe,
    output logic            o_write_strobe_n,
    output logic      [7:0] o_data
);
    initial begin
        {o_action_select_high, o_action_select_low, o_byte_select} = 3'b110;
        {o_load_strobe, o_write_strobe_n, o_data} = 10'h100;
    end
    task automatic step(input int n);
        repeat (n) @(posedge i_ref_clk);
        #1;
    endtask
    // pins held 4 clocks around the strobe, since the port samples them after its synchroniser
    task automatic load(input logic [1:0] mode, input logic bs, input logic [7:0] val);
        step(1);
        {o_action_select_high, o_action_select_low} = mode;
        o_byte_select = bs;
        o_data = val;
        step(4);
        o_load_strobe = 1'b1;
        step(4);
        o_load_strobe = 1'b0;
        step(4);
        o_data = ~val; // released bus never shows the stale value
        {o_action_select_high, o_action_select_low} = 2'b11;
    endtask
    task automatic write_pulse();
        step(1);
        o_write_strobe_n = 1'b0;
        step(4);
        o_write_strobe_n = 1'b1;
        step(4);
    endtask
endmodule // pp_programmer_model
`default_nettype wire

// ==== sim/parallel_program_erase_port_tb_top.sv ====
// self-checking bench for the parallel program/erase port
`timescale 1ns/10ps
`default_nettype none
`include "pp_params.svh"
module parallel_program_erase_port_tb_top;
    localparam int EC = 8;
    logic       i_ref_clk = 1'b0;
    logic       i_resetn = 1'b0;
    logic       preserve = 1'b0;
    logic [7:0] fuse_bits = 8'ha5;
    wire        ash, asl, bs, lds, wrn;
    wire  [7:0] data;
    int         err_total = 0;
    int         checked = 0;
    int         busy_cnt = 0;
    int         pulses = 0;
    always #12.5 i_ref_clk = ~i_ref_clk;
    pp_programmer_model prog (.i_ref_clk(i_ref_clk), .o_action_select_high(ash),
        .o_action_select_low(asl), .o_byte_select(bs), .o_load_strobe(lds),
        .o_write_strobe_n(wrn), .o_data(data));
    pp_port #(.ERASE_CYCLES(EC)) dut (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn),
        .i_action_select_high(ash), .i_action_select_low(asl), .i_byte_select(bs),
        .i_load_strobe(lds), .i_write_strobe_n(wrn), .i_data(data),
        .i_eeprom_preserve_fuse(preserve), .i_fuse_bits(fuse_bits), .o_ready_busy_n(),
        .o_command(), .o_addr_low(), .o_addr_high(), .o_lock_bits_set(), .o_flash_erased(),
        .o_eeprom_erased(), .o_fuse_bits(), .o_page_written(), .o_page_word());
    // sampled mid-cycle so one-cycle pulses are settled
    always @(negedge i_ref_clk) begin
        if (dut.o_ready_busy_n === 1'b0) busy_cnt++;
        if (dut.o_page_written === 1'b1) pulses++;
    end
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask
    task automatic do_reset();
        i_resetn = 1'b0;
        repeat (10) @(posedge i_ref_clk);
        #1 i_resetn = 1'b1;
    endtask
    task automatic wait_idle();
        int n;
        for (n = 0; n < 200 && dut.o_ready_busy_n !== 1'b1; n++) @(negedge i_ref_clk);
        chk(16'(n < 200), 16'h0001, "ready never returned");
    endtask
    task automatic conclude();
        $display("checked %0d, mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic test_reset_state();
        do_reset();
        chk(dut.o_ready_busy_n, 1'b1, "busy after reset");
        chk(dut.o_lock_bits_set, 1'b1, "lock clear after reset");
        $display("test reset_state done");
    endtask
    // erase both with and without the preserve fuse; reset is re-applied mid-run
    task automatic test_erase(input logic keep);
        preserve = keep;
        do_reset();
        busy_cnt = 0;
        prog.load(2'b10, 1'b0, `PP_CMD_CHIP_ERASE);
        chk(dut.o_command, 8'h80, "erase command not latched");
        chk(busy_cnt, 0, "busy before write strobe");
        prog.write_pulse();
        wait_idle();
        chk(busy_cnt, EC + (keep ? 0 : EC) + 1, "erase busy length");
        chk(dut.o_flash_erased, 1'b1, "flash not erased");
        chk(dut.o_eeprom_erased, !keep, "eeprom erase vs preserve");
        chk(dut.o_lock_bits_set, 1'b0, "lock bits kept");
        chk(dut.o_fuse_bits, 8'ha5, "fuse bits changed");
        $display("test erase preserve=%0b done", keep);
    endtask
    // runs after an erase, as a programmer must
    task automatic test_write_flash();
        prog.load(2'b10, 1'b0, `PP_CMD_WRITE_FLASH);
        chk(dut.o_command, 8'h10, "write command not latched");
        prog.load(2'b00, 1'b0, 8'hff);
        chk(dut.o_addr_low, 8'hff, "low address top value");
        prog.load(2'b00, 1'b1, 8'h5a);
        prog.load(2'b00, 1'b0, 8'h00);
        chk(dut.o_addr_low, 8'h00, "low address bottom value");
        chk(dut.o_addr_high, 8'h5a, "high address lost");
        chk(dut.o_command, 8'h10, "command lost");
        pulses = 0;
        // nine words into an eight-deep buffer; erased value 0xff is never sent
        for (int i = 0; i < 9; i++) begin
            prog.load(2'b01, 1'b0, 8'(i + 1));
            prog.load(2'b01, 1'b1, 8'(8'h20 + i));
        end
        chk(pulses, 0, "committed before strobe");
        prog.write_pulse();
        wait_idle();
        repeat (40) @(negedge i_ref_clk);
        chk(pulses, 8, "page word count");
        chk(dut.o_page_word, 16'h2708, "last page word");
        $display("test write_flash done");
    endtask
    initial begin
        #(6000 * 25);
        err_total++;
        $display("unexpected at %0t: watchdog expired", $time);
        conclude();
    end
    initial begin
        test_reset_state();
        test_erase(1'b0);
        test_erase(1'b1);
        test_write_flash();
        conclude();
    end
endmodule // parallel_program_erase_port_tb_top
`default_nettype wire
